// [hw/clcc_pkg.sv]
// package for the closed-loop commutation corrector: register indices,
// field layouts, reset values and timing constants.
// assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses.
`default_nettype none
package clcc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ENC_CONF = 8'h07;
  localparam logic [IDX_W-1:0] IDX_STEP_CONFIG = 8'h0a;
  localparam logic [IDX_W-1:0] IDX_ANGLE_LIMIT = 8'h1c;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h21;
  localparam logic [IDX_W-1:0] IDX_ANGLE = 8'h22;
  localparam logic [IDX_W-1:0] IDX_DEVIATION = 8'h52;
  localparam logic [IDX_W-1:0] IDX_CAL_OFFSET = 8'h59;
  localparam logic [IDX_W-1:0] IDX_GAIN = 8'h5c;
  localparam logic [IDX_W-1:0] IDX_TOLERANCE = 8'h5f;
  localparam logic [IDX_W-1:0] IDX_PERIOD = 8'h63;
  // encoder_input_config fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int CAL_EN_BIT = 2;
  localparam int ABS_ENC_BIT = 3;
  localparam logic [MODE_W-1:0] MODE_CLOSED_LOOP = 2'h1;
  // step_config: microstep_resolution field, code zero means 256 per fullstep
  localparam int MSTEP_W = 4;
  localparam logic [MSTEP_W-1:0] MSTEP_256 = 4'h0;
  // field widths
  localparam int LIMIT_W = 9;
  localparam int GAIN_W = 24;
  localparam int GAIN_FRAC = 16;
  localparam int TOL_W = 8;
  localparam int PERIOD_W = 16;
  localparam int PERIOD_LSB = 16;
  // status bits
  localparam int ST_FIT_BIT = 0;
  localparam int ST_ACTIVE_BIT = 1;
  localparam int ST_LIMIT_BIT = 2;
  // reset values
  localparam logic [LIMIT_W-1:0] RST_LIMIT = 9'h0ff;
  localparam logic [GAIN_W-1:0] RST_GAIN = 24'h01_0000;
  localparam logic [TOL_W-1:0] RST_TOL = 8'h04;
  localparam logic [PERIOD_W-1:0] RST_PERIOD = 16'h0005;
  localparam logic [MSTEP_W-1:0] RST_MSTEP = 4'h8;
  // fastest regulation period with an incremental encoder, in clock cycles
  localparam logic [PERIOD_W-1:0] INCR_PERIOD = 16'h0005;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : clcc_pkg
`default_nettype wire

// [hw/clcc_period_timer.sv]
// regulation tick generator: one-cycle tick every period clock cycles.
// assumes period is stable between ticks; zero behaves as one.
`default_nettype none
module clcc_period_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [clcc_pkg::PERIOD_W-1:0] period,
  output logic tick
);
  import clcc_pkg::*;

  logic [PERIOD_W-1:0] count_r;
  logic tick_r;
  logic [PERIOD_W-1:0] last;

  // terminal count; a zero period still ticks every cycle
  assign last = (period == '0) ? '0 : period - 16'h0001;

  // free-running counter, restarts after each tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else if (count_r >= last) begin
      count_r <= '0;
      tick_r <= 1'b1;
    end else begin
      count_r <= count_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule : clcc_period_timer
`default_nettype wire

// [hw/clcc_corrector.sv]
// closed-loop commutation corrector with its AXI4-Lite register slave.
// assumes ramp position, encoder position and generator step/dir come
// from logic on aclk; the commutation angle feeds the current table.
//
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
module clcc_corrector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [clcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [clcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [clcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [clcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] internal_position,
  input wire logic [31:0] encoder_position,
  input wire logic gen_step,
  input wire logic gen_dir,
  output logic [31:0] commutation_angle,
  output logic step_out,
  output logic dir_out,
  output logic closed_loop_active,
  output logic position_fit_flag,
  output logic position_fit_event,
  output logic angle_limit_event
);
  import clcc_pkg::*;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // software-visible configuration
  logic [MODE_W-1:0] feedback_mode_r;
  logic calibration_enable_r;
  logic absolute_encoder_r;
  logic [MSTEP_W-1:0] microstep_resolution_r;
  logic [LIMIT_W-1:0] angle_limit_r;
  logic [31:0] calibration_offset_r;
  logic [GAIN_W-1:0] gain_r;
  logic [TOL_W-1:0] tolerance_r;
  logic [PERIOD_W-1:0] period_r;

  // bus slave state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [IDX_W-1:0] wr_idx_r;
  logic [31:0] wr_data_r, wr_old, wr_merged;
  logic [3:0] wr_strb_r;
  logic aw_held_r, w_held_r;
  logic wr_fire;
  logic rd_hit;

  // regulation state
  logic [31:0] deviation_r;
  logic [31:0] angle_r;
  logic [31:0] out_pos_r;
  logic step_r, dir_r;
  logic fit_flag_r, fit_event_r, limit_event_r, prev_limit_r;
  logic active_r;
  logic tick;
  logic active;
  logic [PERIOD_W-1:0] eff_period;
  logic [31:0] abs_dev;
  logic within_tol, at_limit;
  logic [55:0] product;
  logic [39:0] scaled;
  logic [31:0] clipped, corr;

  // mode qualifies only at 256 microsteps per fullstep
  assign active = (feedback_mode_r == MODE_CLOSED_LOOP)
                  && (microstep_resolution_r == MSTEP_256);

  // incremental encoders override the programmed period
  assign eff_period = absolute_encoder_r ? period_r : INCR_PERIOD;

  clcc_period_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .period(eff_period),
    .tick(tick)
  );

  // write address channel: held until the write is answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
      wr_idx_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      wr_idx_r <= s_axi_awaddr[IDX_LSB +: IDX_W];
    end else if (s_axi_bvalid && s_axi_bready) begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
      wr_data_r <= '0;
      wr_strb_r <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wr_data_r <= s_axi_wdata;
      wr_strb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
    end
  end

  // the register update and the response share one edge
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  // present image under the byte lanes; encoder config keeps no history
  always_comb begin
    unique case (wr_idx_r)
      IDX_STEP_CONFIG: wr_old = {28'h000_0000, microstep_resolution_r};
      IDX_ANGLE_LIMIT: wr_old = {23'h00_0000, angle_limit_r};
      IDX_CAL_OFFSET: wr_old = calibration_offset_r;
      IDX_GAIN: wr_old = {8'h00, gain_r};
      IDX_TOLERANCE: wr_old = {24'h00_0000, tolerance_r};
      IDX_PERIOD: wr_old = {period_r, 16'h0000};
      default: wr_old = '0;
    endcase
  end
  assign wr_merged = merge(wr_old, wr_data_r, wr_strb_r);

  // write response; unmapped or read-only targets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      unique case (wr_idx_r)
        IDX_ENC_CONF, IDX_STEP_CONFIG, IDX_ANGLE_LIMIT, IDX_CAL_OFFSET,
        IDX_GAIN, IDX_TOLERANCE, IDX_PERIOD: bresp_r <= RESP_OKAY;
        default: bresp_r <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feedback_mode_r <= '0;
      calibration_enable_r <= 1'b0;
      absolute_encoder_r <= 1'b0;
      microstep_resolution_r <= RST_MSTEP;
      angle_limit_r <= RST_LIMIT;
      gain_r <= RST_GAIN;
      tolerance_r <= RST_TOL;
      period_r <= RST_PERIOD;
    end else if (wr_fire) begin
      unique case (wr_idx_r)
        IDX_ENC_CONF: begin
          feedback_mode_r <= wr_merged[MODE_LSB +: MODE_W];
          calibration_enable_r <= wr_merged[CAL_EN_BIT];
          absolute_encoder_r <= wr_merged[ABS_ENC_BIT];
        end
        IDX_STEP_CONFIG: microstep_resolution_r <= wr_merged[MSTEP_W-1:0];
        IDX_ANGLE_LIMIT: angle_limit_r <= wr_merged[LIMIT_W-1:0];
        IDX_GAIN: gain_r <= wr_merged[GAIN_W-1:0];
        IDX_TOLERANCE: tolerance_r <= wr_merged[TOL_W-1:0];
        IDX_PERIOD: period_r <= wr_merged[PERIOD_LSB +: PERIOD_W];
        default: ;
      endcase
    end
  end

  // offset: capture during calibration wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calibration_offset_r <= '0;
    end else if (calibration_enable_r) begin
      calibration_offset_r <= internal_position - encoder_position;
    end else if (wr_fire && wr_idx_r == IDX_CAL_OFFSET) begin
      calibration_offset_r <= wr_merged;
    end
  end

  // read data selection; unused bits read zero
  always_comb begin
    rdata_nxt = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[IDX_LSB +: IDX_W])
      IDX_ENC_CONF: begin
        rdata_nxt[MODE_LSB +: MODE_W] = feedback_mode_r;
        rdata_nxt[CAL_EN_BIT] = calibration_enable_r;
        rdata_nxt[ABS_ENC_BIT] = absolute_encoder_r;
      end
      IDX_STEP_CONFIG: rdata_nxt[MSTEP_W-1:0] = microstep_resolution_r;
      IDX_ANGLE_LIMIT: rdata_nxt[LIMIT_W-1:0] = angle_limit_r;
      IDX_STATUS: begin
        rdata_nxt[ST_FIT_BIT] = fit_flag_r;
        rdata_nxt[ST_ACTIVE_BIT] = active_r;
        rdata_nxt[ST_LIMIT_BIT] = prev_limit_r;
      end
      IDX_ANGLE: rdata_nxt = angle_r;
      IDX_DEVIATION: rdata_nxt = deviation_r;
      IDX_CAL_OFFSET: rdata_nxt = calibration_offset_r;
      IDX_GAIN: rdata_nxt[GAIN_W-1:0] = gain_r;
      IDX_TOLERANCE: rdata_nxt[TOL_W-1:0] = tolerance_r;
      IDX_PERIOD: rdata_nxt[PERIOD_LSB +: PERIOD_W] = period_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one read in flight, data registered at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // deviation tracks every cycle, offset included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deviation_r <= '0;
    end else begin
      deviation_r <= internal_position - encoder_position - calibration_offset_r;
    end
  end

  // magnitude path; the sign is reapplied after clipping
  assign abs_dev = deviation_r[31] ? (32'h0000_0000 - deviation_r) : deviation_r;
  assign within_tol = abs_dev <= {24'h00_0000, tolerance_r};
  assign at_limit = abs_dev >= {23'h00_0000, angle_limit_r};
  assign product = abs_dev * gain_r;
  // unity factor inside tolerance keeps the angle on the ramp position
  assign scaled = within_tol ? {8'h00, abs_dev}
                             : product[GAIN_FRAC +: 40];
  assign clipped = (scaled > {31'h0000_0000, angle_limit_r})
                   ? {23'h00_0000, angle_limit_r} : scaled[31:0];
  assign corr = deviation_r[31] ? (32'h0000_0000 - clipped) : clipped;

  // regulation step, once per tick; open loop follows the ramp directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      angle_r <= '0;
      active_r <= 1'b0;
    end else if (!active) begin
      angle_r <= internal_position;
      active_r <= 1'b0;
    end else if (tick) begin
      // angle built from the encoder, not from the step generator
      angle_r <= encoder_position + calibration_offset_r + corr;
      active_r <= 1'b1;
    end
  end

  // fit flag and events, pulses only on a qualifying regulation tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fit_flag_r <= 1'b1;
      prev_limit_r <= 1'b0;
      fit_event_r <= 1'b0;
      limit_event_r <= 1'b0;
    end else if (tick && active) begin
      fit_flag_r <= within_tol;
      prev_limit_r <= at_limit;
      fit_event_r <= within_tol && !fit_flag_r;
      limit_event_r <= at_limit && !prev_limit_r;
    end else begin
      fit_event_r <= 1'b0;
      limit_event_r <= 1'b0;
    end
  end

  // step/dir: gated by the reported state so the pins switch with closed_loop_active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pos_r <= '0;
      step_r <= 1'b0;
      dir_r <= 1'b0;
    end else if (!active_r) begin
      out_pos_r <= internal_position;
      step_r <= gen_step;
      dir_r <= gen_dir;
    end else if (step_r) begin
      step_r <= 1'b0; // one-cycle pulse, then a low cycle
    end else if (angle_r != out_pos_r) begin
      step_r <= 1'b1;
      dir_r <= $signed(angle_r - out_pos_r) > 0;
      out_pos_r <= ($signed(angle_r - out_pos_r) > 0)
                   ? out_pos_r + 32'h0000_0001 : out_pos_r - 32'h0000_0001;
    end
  end

  // all outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign commutation_angle = angle_r;
  assign step_out = step_r;
  assign dir_out = dir_r;
  assign closed_loop_active = active_r;
  assign position_fit_flag = fit_flag_r;
  assign position_fit_event = fit_event_r;
  assign angle_limit_event = limit_event_r;
endmodule : clcc_corrector
`default_nettype wire

// [testbench/clcc_props.sv]
// port checker for the closed-loop commutation corrector.
// assumes a bind onto clcc_corrector, one aclk domain, sync low reset.
`default_nettype none
module clcc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [clcc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gen_step,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic closed_loop_active,
  input wire logic position_fit_flag,
  input wire logic position_fit_event,
  input wire logic angle_limit_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import clcc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // open loop: generator steps pass one cycle late; guard the reset edge
  a_step_follow_open: assert property (
    !closed_loop_active && !$past(closed_loop_active) && $past(aresetn)
    |-> step_out == $past(gen_step)) else $error("open loop step not passed");
  // closed loop steps are single pulses
  a_step_pulse_closed: assert property (
    closed_loop_active && $past(closed_loop_active, 2) && step_out
    |=> !step_out) else $error("closed loop step wider than one cycle");
  // direction only moves together with a step pulse
  a_dir_with_step: assert property (
    closed_loop_active && $past(closed_loop_active, 2) && $changed(dir_out)
    |-> step_out) else $error("direction changed without a step");
  a_fit_pulse: assert property (
    position_fit_event |=> !position_fit_event [*2]) else $error("fit event too long");
  a_limit_pulse: assert property (
    angle_limit_event |=> !angle_limit_event) else $error("limit event too long");
  // a fit event needs a mismatch just before and the flag set in the same cycle
  a_fit_event_cause: assert property (
    position_fit_event |-> position_fit_flag &&
    (!$past(position_fit_flag) || !$past(position_fit_flag, 2)))
    else $error("fit event without cleared mismatch");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_stable: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  cover property (angle_limit_event);
  cover property (position_fit_event);
  cover property (closed_loop_active && step_out);
endmodule : clcc_props
bind clcc_corrector clcc_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gen_step, .step_out, .dir_out,
  .closed_loop_active, .position_fit_flag, .position_fit_event, .angle_limit_event);
`default_nettype wire

// [testbench/clcc_motor_model.sv]
// encoder and motor driver model facing the corrector.
// assumes a stalled load: the encoder reports mech_pos, the driver counts steps.
`default_nettype none
module clcc_motor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic [31:0] mech_pos,
  output logic [31:0] encoder_position,
  output logic [31:0] driver_steps
);
  timeunit 1ns;
  timeprecision 1ps;
  // encoder sample one cycle late, like a real capture register
  always_ff @(posedge aclk) begin
    encoder_position <= mech_pos;
  end
  // driver position follows step pulses, dir high counts up
  always_ff @(posedge aclk) begin
    if (!aresetn)
      driver_steps <= 32'h0000_0000;
    else if (step_out)
      driver_steps <= dir_out ? driver_steps + 1 : driver_steps - 1;
  end
endmodule : clcc_motor_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the closed-loop commutation corrector.
// assumes the AXI4-Lite timing of the hand-over and the stalled motor model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clcc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] internal_position, encoder_position, commutation_angle, mech_pos, driver_steps;
  logic gen_step, gen_dir, step_out, dir_out, closed_loop_active;
  logic position_fit_flag, position_fit_event, angle_limit_event;
  int error_cnt, cmp_count, fit_evs, lim_evs;
  clcc_corrector uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .internal_position, .encoder_position,
    .gen_step, .gen_dir, .commutation_angle, .step_out, .dir_out, .closed_loop_active,
    .position_fit_flag, .position_fit_event, .angle_limit_event);
  clcc_motor_model u_motor (.aclk, .aresetn, .step_out, .dir_out, .mech_pos,
    .encoder_position, .driver_steps);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // generator toggles every cycle; event pulses are counted here
  always @(posedge aclk) begin
    gen_step <= !gen_step;
    if (position_fit_event === 1'b1)
      fit_evs <= fit_evs + 1;
    if (angle_limit_event === 1'b1)
      lim_evs <= lim_evs + 1;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] idx);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // expected angle from deviation, gain and limit at the reset tolerance
  function automatic logic [31:0] exp_angle(int dev, longint gain, longint lim, int base);
    longint m, c;
    m = dev < 0 ? -dev : dev;
    c = m <= RST_TOL ? m : (m * gain) >> 16;
    if (c > lim)
      c = lim;
    return 32'(base + (dev < 0 ? -c : c));
  endfunction : exp_angle
  task automatic test_regs();
    axi_read(IDX_ANGLE_LIMIT);
    check("limit", rd, 32'(RST_LIMIT));
    axi_read(IDX_GAIN);
    check("gain", rd, 32'(RST_GAIN));
    axi_read(IDX_TOLERANCE);
    check("tolerance", rd, 32'(RST_TOL));
    axi_read(IDX_PERIOD);
    check("period", rd, {RST_PERIOD, 16'h0000});
    axi_read(8'h01);
    check("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_write(IDX_DEVIATION, 32'h0000_1234);
    check("ro write", {30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask : test_regs
  // mode set but 8 microsteps: stays open loop, deviation still tracked
  task automatic test_deviation();
    internal_position <= 32'd1000;
    mech_pos <= 32'd990;
    axi_write(IDX_ENC_CONF, 32'h0000_0001);
    repeat (12) @(posedge aclk);
    check("active", {31'h0, closed_loop_active}, 32'h0);
    axi_read(IDX_DEVIATION);
    check("dev pos", rd, 32'd10);
    mech_pos <= 32'd1010;
    repeat (4) @(posedge aclk);
    axi_read(IDX_DEVIATION);
    check("dev neg", rd, 32'hffff_fff6);
    mech_pos <= 32'd990;
    axi_write(IDX_CAL_OFFSET, 32'h0000_0003);
    axi_read(IDX_CAL_OFFSET);
    check("offset", rd, 32'd3);
    axi_read(IDX_DEVIATION);
    check("dev offset", rd, 32'd7);
    axi_write(IDX_CAL_OFFSET, 32'h0000_0000);
  endtask : test_deviation
  task automatic test_calibrate();
    axi_write(IDX_STEP_CONFIG, {28'h0, MSTEP_256});
    axi_write(IDX_ENC_CONF, 32'h0000_0005);
    repeat (20) @(posedge aclk);
    axi_write(IDX_ENC_CONF, 32'h0000_0001);
    axi_read(IDX_CAL_OFFSET);
    check("cal offset", rd, 32'd10);
    axi_read(IDX_DEVIATION);
    check("cal dev", rd, 32'd0);
    check("active", {31'h0, closed_loop_active}, 32'h1);
    check("fit flag", {31'h0, position_fit_flag}, 32'h1);
  endtask : test_calibrate
  // encoder 990 and offset 10: angle base is 1000
  task automatic test_regulate();
    int ip[5] = '{1030, 1030, 1030, 1002, 970};
    int gn[5] = '{32'h1_0000, 32'h1_8000, 32'h1_8000, 32'h1_8000, 32'h1_8000};
    int lm[5] = '{255, 255, 20, 20, 20};
    logic [31:0] prev, exp, steps0;
    int fit0, lim0;
    prev = 32'd1000;
    fit0 = fit_evs;
    lim0 = lim_evs;
    for (int i = 0; i < 5; i++) begin
      steps0 = driver_steps;
      axi_write(IDX_GAIN, 32'(gn[i]));
      axi_write(IDX_ANGLE_LIMIT, 32'(lm[i]));
      internal_position <= 32'(ip[i]);
      repeat (80) @(posedge aclk);
      exp = exp_angle(ip[i] - 1000, gn[i], lm[i], 1000);
      check("angle", commutation_angle, exp);
      check("fit", {31'h0, position_fit_flag}, 32'(ip[i] == 1002));
      check("steps", driver_steps - steps0, exp - prev);
      prev = exp;
    end
    check("limit events", 32'(lim_evs - lim0), 32'd2);
    check("fit events", 32'(fit_evs - fit0), 32'd1);
  endtask : test_regulate
  // saved offset loaded in place of calibration, then the status word
  task automatic test_saved_offset();
    axi_write(IDX_ENC_CONF, 32'h0000_0000);
    axi_write(IDX_CAL_OFFSET, 32'h0000_0005);
    axi_write(IDX_ENC_CONF, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    axi_read(IDX_DEVIATION);
    check("saved dev", rd, 32'hffff_ffe7);
    axi_read(IDX_ANGLE);
    check("angle reg", rd, exp_angle(-25, 32'h1_8000, 20, 995));
    axi_read(IDX_STATUS);
    check("status", rd, 32'h0000_0006);
  endtask : test_saved_offset
  // absolute encoder: the angle refreshes once per programmed period
  task automatic test_period();
    logic [31:0] a0;
    int n;
    axi_write(IDX_PERIOD, {16'h0028, 16'h0000});
    axi_write(IDX_ENC_CONF, 32'h0000_0009);
    internal_position <= 32'd1010;
    a0 = commutation_angle;
    do @(posedge aclk); while (commutation_angle == a0);
    a0 = commutation_angle;
    internal_position <= 32'd990;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (commutation_angle == a0 && n < 100);
    check("period ticks", 32'(n), 32'd40);
  endtask : test_period
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, internal_position, mech_pos} = '0;
    s_axi_wstrb = 4'hf;
    gen_step = 1'b0;
    gen_dir = 1'b1;
    {error_cnt, cmp_count, fit_evs, lim_evs} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_deviation();
    test_calibrate();
    test_regulate();
    test_saved_offset();
    test_period();
    give_verdict();
  end
  // whole run needs about 650 cycles
  initial begin
    repeat (10000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
